// *** design/ftx_pkg.sv ***
// Purpose: Shared constants, types and helpers of the transmit symbol mapper.
// Assumes: 32-bit Wishbone register words, byte addresses.
// Notes: Levels are signed multiples of the inner deviation.

package ftx_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] FTX_ADDR_CTRL = 4'h0;
	localparam logic [3:0] FTX_ADDR_CFG2 = 4'h4;
	localparam logic [3:0] FTX_ADDR_CFG3 = 4'h8;
	localparam logic [3:0] FTX_ADDR_STAT = 4'hC;

	// ==========================================================
	// Field positions and widths
	localparam int FTX_MOD_LSB = 4;
	localparam int FTX_MOD_W = 3;
	localparam int FTX_DEV_LSB = 19;
	localparam int FTX_DEV_W = 9;
	localparam int FTX_ALPHA_BIT = 30;
	localparam int FTX_DEMOD_LSB = 6;
	localparam int FTX_DEMOD_W = 4;
	localparam int FTX_RECOV_LSB = 10;
	localparam int FTX_RECOV_W = 8;
	localparam int FTX_TXEN_BIT = 0;
	localparam int FTX_HALVE_BIT = 1;
	localparam int FTX_UART_BIT = 2;

	// ==========================================================
	// Reset values and counts
	localparam logic [2:0] FTX_MOD_RST = 3'h0;
	localparam logic [8:0] FTX_DEV_RST = 9'h001;
	localparam logic [3:0] FTX_DEMOD_RST = 4'h1;
	localparam logic [7:0] FTX_RECOV_RST = 8'h01;
	localparam logic [15:0] FTX_HALF_MULT = 16'h0010; // Half of the 32 division

	// ==========================================================
	// Modulation codes and filter selections
	localparam logic [2:0] FTX_MOD_2L = 3'h0;
	localparam logic [2:0] FTX_MOD_2L_GAUSS = 3'h1;
	localparam logic [2:0] FTX_MOD_3L = 3'h2;
	localparam logic [2:0] FTX_MOD_4L = 3'h3;
	localparam logic [2:0] FTX_MOD_2L_OVER = 3'h4;
	localparam logic [2:0] FTX_MOD_2L_RC = 3'h5;
	localparam logic [2:0] FTX_MOD_3L_RC = 3'h6;
	localparam logic [2:0] FTX_MOD_4L_RC = 3'h7;
	localparam logic [1:0] FTX_FLT_NONE = 2'h0;
	localparam logic [1:0] FTX_FLT_GAUSS = 2'h1;
	localparam logic [1:0] FTX_FLT_RC = 2'h2;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [2:0] mod_code;
		logic [8:0] deviation;
		logic alpha_high;
		logic [3:0] demodulator_clock_divider;
		logic [7:0] recovery_clock_divider;
		logic output_halving_select;
		logic tx_enable;
		logic uart_mode;
	} ftx_cfg_t;

	typedef enum logic {FTX_IDLE, FTX_RUN} ftx_state_t;

	// ==========================================================
	// Helpers
	// Two-level bit to level
	function automatic logic signed [2:0] ftx_map2(input logic b);
		return b ? 3'sh1 : 3'sh7;
	endfunction : ftx_map2

	// Gray pair to level: 00 -3, 01 -1, 11 +1, 10 +3
	function automatic logic signed [2:0] ftx_map4(input logic [1:0] p);
		logic signed [2:0] l;
		l = 3'sh0;
		unique case (p)
			2'h0: l = 3'sh5;
			2'h1: l = 3'sh7;
			2'h3: l = 3'sh1;
			2'h2: l = 3'sh3;
		endcase
		return l;
	endfunction : ftx_map4

	// Offset in half steps of the deviation unit
	function automatic logic signed [12:0] ftx_scale(input logic signed [2:0] lvl, input logic [8:0] dev,
		input logic halve);
		logic signed [12:0] prod;
		prod = 13'(lvl) * $signed({4'h0, dev});
		return halve ? prod : (prod <<< 1);
	endfunction : ftx_scale

	// Byte-lane merge of a write
	function automatic logic [31:0] ftx_merge(input logic [31:0] cur, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = cur;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : ftx_merge

endpackage : ftx_pkg

// *** design/ftx_sync.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to ref_clk.
// Notes: Output moves only when stages two and three agree.

`timescale 1ns/1ns

module ftx_sync import ftx_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);

	logic ff1;
	logic ff2;
	logic ff3;

	// ==========================================================
	// Chain and filter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			ff1 <= async_in;
			ff2 <= ff1;
			ff3 <= ff2;
			if (ff2 == ff3) begin
				sync_out <= ff3;
			end
		end
	end

endmodule : ftx_sync

// *** design/ftx_precoder.sv ***
// Purpose: Three-level precoder and 1-D^2 encoder.
// Assumes: One step per transmit bit.
// Notes: Clear empties both delay stages.

`timescale 1ns/1ns

module ftx_precoder import ftx_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic step,
	input wire logic din,
	output logic signed [2:0] enc
);

	logic p1;
	logic p2;
	wire next_p;
	wire signed [2:0] next_enc;

	// ==========================================================
	// Precoder and encoder arithmetic
	assign next_p = din ^ p2;
	assign next_enc = (next_p == p2) ? 3'sh0 : (next_p ? 3'sh1 : 3'sh7);

	// Delay stages
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			p1 <= 1'b0;
			p2 <= 1'b0;
			enc <= 3'sh0;
		end else if (clear) begin
			p1 <= 1'b0;
			p2 <= 1'b0;
			enc <= 3'sh0;
		end else if (step) begin
			p1 <= next_p;
			p2 <= p1;
			enc <= next_enc;
		end
	end

	// ==========================================================
	// Checks
	precoder_xor_a: assert property (@(posedge ref_clk) disable iff (rst)
		step && !clear |=> p1 == ($past(din) ^ $past(p2)))
		else $error("precoder output is not input xor two back");
	encoder_diff_a: assert property (@(posedge ref_clk) disable iff (rst)
		step && !clear |=> ((enc == 3'sh0) == (p1 == $past(p2))) && ((enc == 3'sh1) == (p1 && !$past(p2))))
		else $error("encoder output is not current minus two back");

endmodule : ftx_precoder

// *** design/ftx_symbol_mapper.sv ***
// Purpose: Transmit data clock, bit sampling and symbol mapping of an FSK transmitter.
// Assumes: Classic Wishbone register access, ref_clk is the reference.
// Notes: freq_offset is in units of half a deviation step.
//
// How it works
// - Clock pin runs at reference over demod times recovery divider times 32.
// - Dividers sit in config word 3, bits 6-9 and 10-17.
// - Nine-bit deviation word scales every level.
// - Halving select gives half the deviation of direct output.
// - Four-level gray pairs map to plus/minus three or one deviation.
// - Outer four-level levels are exactly three times the inner.
// - Four-level groups bits in pairs, symbol rate half bit rate.
// - Code 000 shifts the divide value by each bit, two-level.
// - Three-level zero gives carrier, nonzero gives carrier plus or minus deviation.
// - Precoder output is input xor precoder output two bits earlier.
// - Encoder output is precoder now minus precoder two bits back.
// - Code 010 selects three-level, one symbol per bit.
// - Code 100 drives no clock and samples data at 32 times rate.
// - Asynchronous serial data only allowed with oversampled two-level mode.
// - Gaussian filter only with two-level, code 001.
// - Raised-cosine roll-off 0.5, or 0.7 when word 2 bit 30 set.
// - Raised-cosine codes 101, 110, 111 for two, three, four levels.
// - Modulation select is word 2 bits 4-6; 011 is unfiltered four-level.
// - Unfiltered two-level output lags sampling by one bit.
//
// The implementer's own choices: the address map and the Wishbone register port.

`timescale 1ns/1ns

module ftx_symbol_mapper import ftx_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [3:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_wr,
	output logic [31:0] wb_dat_rd,
	output logic wb_ack,
	input wire logic transmit_bit_input,
	output logic transceive_clock_pin,
	output logic transceive_clock_pin_oe,
	output logic signed [2:0] symbol_level,
	output logic signed [12:0] freq_offset,
	output logic symbol_strobe,
	output logic [1:0] filter_select,
	output logic rc_alpha_high,
	output logic tx_active
);

	// ==========================================================
	// Elaboration check
	if (CNT_W < 16) begin : g_bad_width
		$error("CNT_W must hold the longest half period");
	end

	ftx_cfg_t cfg;
	ftx_state_t state;
	ftx_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic pair_phase;
	logic msb;
	logic signed [2:0] pending_lvl;
	logic signed [2:0] level;
	logic [CNT_W-1:0] tog_cnt;
	wire data;
	wire signed [2:0] enc;

	// ==========================================================
	// Bus decode
	wire access = wb_cyc && wb_stb && !wb_ack;
	wire wr_take = wb_cyc && wb_stb && wb_ack && wb_we;
	wire wr_ctrl = wr_take && (wb_adr == FTX_ADDR_CTRL);
	wire wr_cfg2 = wr_take && (wb_adr == FTX_ADDR_CFG2);
	wire wr_cfg3 = wr_take && (wb_adr == FTX_ADDR_CFG3);
	wire wr_any = wr_ctrl || wr_cfg2 || wr_cfg3;

	// Register words assembled from fields
	wire [31:0] ctrl_word = (32'(cfg.tx_enable) << FTX_TXEN_BIT) | (32'(cfg.output_halving_select) << FTX_HALVE_BIT)
		| (32'(cfg.uart_mode) << FTX_UART_BIT);
	wire [31:0] cfg2_word = (32'(cfg.alpha_high) << FTX_ALPHA_BIT) | (32'(cfg.deviation) << FTX_DEV_LSB)
		| (32'(cfg.mod_code) << FTX_MOD_LSB);
	wire [31:0] cfg3_word = (32'(cfg.demodulator_clock_divider) << FTX_DEMOD_LSB)
		| (32'(cfg.recovery_clock_divider) << FTX_RECOV_LSB);
	wire [31:0] ctrl_new = ftx_merge(ctrl_word, wb_dat_wr, wb_sel);
	wire [31:0] cfg2_new = ftx_merge(cfg2_word, wb_dat_wr, wb_sel);
	wire [31:0] cfg3_new = ftx_merge(cfg3_word, wb_dat_wr, wb_sel);

	// ==========================================================
	// Mode decode
	wire [2:0] mode = cfg.mod_code;
	wire is_over = (mode == FTX_MOD_2L_OVER);
	wire is_two = (mode == FTX_MOD_2L) || (mode == FTX_MOD_2L_GAUSS) || (mode == FTX_MOD_2L_RC);
	wire is_three = (mode == FTX_MOD_3L) || (mode == FTX_MOD_3L_RC);
	wire is_four = (mode == FTX_MOD_4L) || (mode == FTX_MOD_4L_RC);
	wire is_gauss = (mode == FTX_MOD_2L_GAUSS);
	wire is_rc = (mode == FTX_MOD_2L_RC) || (mode == FTX_MOD_3L_RC) || (mode == FTX_MOD_4L_RC);
	wire [1:0] next_filter = is_gauss ? FTX_FLT_GAUSS : (is_rc ? FTX_FLT_RC : FTX_FLT_NONE);
	wire uart_conflict = cfg.uart_mode && !is_over;
	wire dev_invalid = (cfg.deviation == 9'h000);
	wire run_ok = cfg.tx_enable && !uart_conflict;
	wire running = (state == FTX_RUN);

	// ==========================================================
	// Divider terms, zero divider acts as one
	wire [3:0] dmd = (cfg.demodulator_clock_divider == 4'h0) ? 4'h1 : cfg.demodulator_clock_divider;
	wire [7:0] rcv = (cfg.recovery_clock_divider == 8'h00) ? 8'h01 : cfg.recovery_clock_divider;
	wire [11:0] div_prod = 12'(dmd) * 12'(rcv);
	wire [CNT_W-1:0] half_period = CNT_W'(16'(div_prod) * FTX_HALF_MULT);
	wire [CNT_W-1:0] os_period = CNT_W'(div_prod);
	wire [CNT_W-1:0] term = is_over ? os_period : half_period;
	wire cnt_hit = running && (cnt == term - CNT_W'(1));
	// Any register write restarts the half period, so a mode change never overshoots the terminal count
	wire [CNT_W-1:0] next_cnt = (!running || cnt_hit || wr_any) ? '0 : cnt + CNT_W'(1);
	wire next_clk_pin = running && !is_over && (cnt_hit ? !transceive_clock_pin : transceive_clock_pin);

	// Sampling events
	wire bit_tick = cnt_hit && !is_over && !transceive_clock_pin;
	wire os_tick = cnt_hit && is_over;
	wire sym_fire = (bit_tick && (is_two || is_three || (is_four && pair_phase))) || os_tick;
	wire signed [2:0] cur_level = is_three ? enc : level;
	wire signed [12:0] next_offset = running ? ftx_scale(cur_level, cfg.deviation, cfg.output_halving_select)
		: 13'sh0;

	// ==========================================================
	// Transmit state, a divider write restarts the clock
	always_comb begin
		next_state = state;
		unique case (state)
			FTX_IDLE: next_state = run_ok ? FTX_RUN : FTX_IDLE;
			FTX_RUN: next_state = (!run_ok || wr_cfg3) ? FTX_IDLE : FTX_RUN;
		endcase
	end

	// Data pin synchroniser
	ftx_sync u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(transmit_bit_input),
		.sync_out(data)
	);

	// Three-level coder, cleared while idle
	ftx_precoder u_precoder (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(!running),
		.step(bit_tick && is_three),
		.din(data),
		.enc(enc)
	);

	// ==========================================================
	// Register file
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg <= '{FTX_MOD_RST, FTX_DEV_RST, 1'b0, FTX_DEMOD_RST, FTX_RECOV_RST, 1'b0, 1'b0, 1'b0};
		end else begin
			if (wr_ctrl) begin
				cfg.tx_enable <= ctrl_new[FTX_TXEN_BIT];
				cfg.output_halving_select <= ctrl_new[FTX_HALVE_BIT];
				cfg.uart_mode <= ctrl_new[FTX_UART_BIT];
			end
			if (wr_cfg2) begin
				cfg.mod_code <= cfg2_new[FTX_MOD_LSB +: FTX_MOD_W];
				cfg.deviation <= cfg2_new[FTX_DEV_LSB +: FTX_DEV_W];
				cfg.alpha_high <= cfg2_new[FTX_ALPHA_BIT];
			end
			if (wr_cfg3) begin
				cfg.demodulator_clock_divider <= cfg3_new[FTX_DEMOD_LSB +: FTX_DEMOD_W];
				cfg.recovery_clock_divider <= cfg3_new[FTX_RECOV_LSB +: FTX_RECOV_W];
			end
		end
	end

	// Read mux, unmapped reads zero
	wire [31:0] stat_word = {27'h0, transceive_clock_pin, pair_phase, dev_invalid, uart_conflict, running};
	wire [31:0] rd_word = (wb_adr == FTX_ADDR_CTRL) ? ctrl_word :
		(wb_adr == FTX_ADDR_CFG2) ? cfg2_word :
		(wb_adr == FTX_ADDR_CFG3) ? cfg3_word :
		(wb_adr == FTX_ADDR_STAT) ? stat_word : 32'h0;

	// Bus answer one cycle after request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack <= 1'b0;
			wb_dat_rd <= 32'h0;
		end else begin
			wb_ack <= access;
			if (access) begin
				wb_dat_rd <= rd_word;
			end
		end
	end

	// ==========================================================
	// Clock divider and pin
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= FTX_IDLE;
			cnt <= '0;
			transceive_clock_pin <= 1'b0;
			transceive_clock_pin_oe <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			transceive_clock_pin <= next_clk_pin;
			transceive_clock_pin_oe <= running && !is_over;
		end
	end

	// Bit pairing and level pipeline
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pair_phase <= 1'b0;
			msb <= 1'b0;
			pending_lvl <= 3'sh0;
			level <= 3'sh0;
		end else if (!running) begin
			pair_phase <= 1'b0;
			pending_lvl <= 3'sh0;
			level <= 3'sh0;
		end else if (os_tick) begin
			level <= ftx_map2(data);
		end else if (bit_tick && is_four) begin
			pair_phase <= !pair_phase;
			if (!pair_phase) begin
				msb <= data;
			end else begin
				pending_lvl <= ftx_map4({msb, data});
				level <= pending_lvl;
			end
		end else if (bit_tick && is_two) begin
			pending_lvl <= ftx_map2(data);
			level <= pending_lvl;
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			symbol_level <= 3'sh0;
			freq_offset <= 13'sh0;
			symbol_strobe <= 1'b0;
			filter_select <= FTX_FLT_NONE;
			rc_alpha_high <= 1'b0;
			tx_active <= 1'b0;
		end else begin
			symbol_level <= running ? cur_level : 3'sh0;
			freq_offset <= next_offset;
			symbol_strobe <= sym_fire;
			filter_select <= next_filter;
			rc_alpha_high <= is_rc && cfg.alpha_high;
			tx_active <= running;
		end
	end

	// Cycles since the last clock pin change
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tog_cnt <= CNT_W'(1);
		end else if (!running || wr_any || (next_clk_pin != transceive_clock_pin)) begin
			tog_cnt <= CNT_W'(1);
		end else begin
			tog_cnt <= tog_cnt + CNT_W'(1);
		end
	end

	// ==========================================================
	// Checks
	default clocking ck @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_blocked;
		uart_conflict && running;
	endsequence
	sequence s_drops;
		(state == FTX_IDLE) ##1 !tx_active;
	endsequence

	clk_half_a: assert property (bit_tick || (cnt_hit && !is_over) |-> tog_cnt == half_period)
		else $error("clock pin half period wrong");
	clk_off_a: assert property (running && is_over ##1 is_over |-> !transceive_clock_pin_oe)
		else $error("clock pin driven in oversampled mode");
	uart_block_a: assert property (s_blocked |=> s_drops)
		else $error("uart data allowed outside oversampled mode");
	pair_rate_a: assert property (bit_tick && is_four |-> sym_fire == pair_phase)
		else $error("four-level symbol not every second bit");
	gray_map_a: assert property (bit_tick && is_four && pair_phase |=>
		pending_lvl == ftx_map4({$past(msb), $past(data)}))
		else $error("gray pair mapped wrongly");
	halve_a: assert property (tx_active && $past(cfg.output_halving_select) |->
		(freq_offset <<< 1) == ftx_scale(symbol_level, $past(cfg.deviation), 1'b0))
		else $error("halved deviation not half of direct");
	scale_a: assert property (tx_active && !$past(cfg.output_halving_select) && symbol_level == 3'sh1 |->
		freq_offset == $signed({3'h0, $past(cfg.deviation), 1'b0}))
		else $error("deviation word not applied");
	outer_a: assert property (tx_active && symbol_level == 3'sh3 |->
		freq_offset == ftx_scale(3'sh1, $past(cfg.deviation), $past(cfg.output_halving_select)) * 13'sh3)
		else $error("outer level not three times inner");
	three_zero_a: assert property (running && is_three && enc == 3'sh0 ##1 running |-> freq_offset == 13'sh0)
		else $error("three-level zero not carrier");
	latency_a: assert property (bit_tick && is_two |=>
		level == $past(pending_lvl) && pending_lvl == ftx_map2($past(data)))
		else $error("two-level latency not one bit");

endmodule : ftx_symbol_mapper

// *** testbench/ftx_host_model.sv ***
// Purpose: Host side of the transmit data pins.
// Assumes: Bits leave MSB first, one per data clock period.
// Notes: Data moves just after each falling clock edge.

`timescale 1ns/1ns

module ftx_host_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic transceive_clock_pin,
	input wire logic transceive_clock_pin_oe,
	input wire logic [15:0] pattern,
	output logic transmit_bit_input
);
	logic [3:0] bit_idx;
	logic pin_prev;

	// ==========================================================
	// Bit pointer: restarts while the clock pin is not driven
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_idx <= 4'h0;
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= transceive_clock_pin;
			if (!transceive_clock_pin_oe) begin
				bit_idx <= 4'h0;
			end else if (pin_prev && !transceive_clock_pin) begin
				bit_idx <= bit_idx + 4'h1;
			end
		end
	end

	// First bit stands before the first rising clock edge
	assign transmit_bit_input = pattern[4'hF - bit_idx];
endmodule : ftx_host_model

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench of the transmit symbol mapper.
// Assumes: Host model feeds the data pin from a 16-bit pattern.
// Notes: Levels are sampled two cycles after each symbol strobe.

`timescale 1ns/1ns

module tb_top import ftx_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_wr = 32'h0;
	logic [31:0] wb_dat_rd;
	logic wb_ack;
	logic transmit_bit_input;
	logic transceive_clock_pin;
	logic transceive_clock_pin_oe;
	logic signed [2:0] symbol_level;
	logic signed [12:0] freq_offset;
	logic symbol_strobe;
	logic [1:0] filter_select;
	logic rc_alpha_high;
	logic tx_active;
	logic [15:0] pattern = 16'h0;
	int err_total = 0;
	int checks_done = 0;
	logic [31:0] rd;

	// ==========================================================
	// Clock, design and host
	always #50 ref_clk = ~ref_clk;

	ftx_symbol_mapper dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
		.transmit_bit_input(transmit_bit_input), .transceive_clock_pin(transceive_clock_pin),
		.transceive_clock_pin_oe(transceive_clock_pin_oe), .symbol_level(symbol_level),
		.freq_offset(freq_offset), .symbol_strobe(symbol_strobe), .filter_select(filter_select),
		.rc_alpha_high(rc_alpha_high), .tx_active(tx_active));

	ftx_host_model host (.ref_clk(ref_clk), .rst(rst), .transceive_clock_pin(transceive_clock_pin),
		.transceive_clock_pin_oe(transceive_clock_pin_oe), .pattern(pattern),
		.transmit_bit_input(transmit_bit_input));

	// ==========================================================
	// Verdict and shared helpers
	task automatic test_done();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic timed_out(input string what);
		err_total++;
		$display("ERROR %s expected event seen timeout", what);
		test_done();
	endtask : timed_out

	// Classic cycle, released at the edge where ack is high
	task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_wr <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) timed_out("wb_ack");
		q = wb_dat_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_xfer

	task automatic wait_strobe();
		int n;
		n = 0;
		while (symbol_strobe !== 1'b1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 5000) timed_out("symbol_strobe");
		@(negedge ref_clk);
		@(negedge ref_clk);
	endtask : wait_strobe

	task automatic setup(input logic [2:0] m, input logic [8:0] dev, input logic [3:0] dmd, input logic [7:0] rcv,
		input logic [2:0] ctl);
		wb_xfer(1'b1, FTX_ADDR_CTRL, 32'h0, rd);
		wb_xfer(1'b1, FTX_ADDR_CFG2, {4'h0, dev, 12'h0, m, 4'h0}, rd);
		wb_xfer(1'b1, FTX_ADDR_CFG3, {14'h0, rcv, dmd, 6'h0}, rd);
		wb_xfer(1'b1, FTX_ADDR_CTRL, {29'h0, ctl}, rd);
	endtask : setup

	// ==========================================================
	// Scenario: one symbol run in mode m, bits MSB first from pat
	task automatic run_symbols(input logic [2:0] m, input logic [15:0] pat, input int nsym, input int lag,
		input logic [8:0] dev, input logic halve);
		logic [15:0] p;
		int b;
		int lvl;
		pattern <= pat;
		setup(m, dev, 4'h1, 8'h01, {1'b0, halve, 1'b1});
		p = 16'h0;
		for (int i = 0; i < nsym + lag; i++) begin
			wait_strobe();
			if (i >= lag) begin
				b = i - lag;
				if (m == FTX_MOD_2L) lvl = pat[15 - b] ? 1 : -1;
				if (m == FTX_MOD_3L) begin
					p[b] = pat[15 - b] ^ ((b >= 2) ? p[b - 2] : 1'b0);
					lvl = int'(p[b]) - ((b >= 2) ? int'(p[b - 2]) : 0);
				end
				if (m == FTX_MOD_4L) begin
					case (pat[15 - 2 * b -: 2])
						2'h0: lvl = -3;
						2'h1: lvl = -1;
						2'h3: lvl = 1;
						default: lvl = 3;
					endcase
				end
				chk("symbol_level", 32'(signed'(3'(lvl))), 32'(symbol_level));
				chk("freq_offset", 32'(signed'(13'(lvl * dev * (halve ? 1 : 2)))), 32'(freq_offset));
			end
		end
	endtask : run_symbols

	// Scenario: data clock low half period from both dividers
	task automatic clock_period();
		int n;
		setup(FTX_MOD_2L, 9'h005, 4'h2, 8'h03, 3'h1);
		n = 0;
		while (transceive_clock_pin !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		while (transceive_clock_pin !== 1'b0 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		while (transceive_clock_pin !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("data clock low half", 32'd96, 32'(n));
		chk("clock pin oe", 32'h1, 32'(transceive_clock_pin_oe));
	endtask : clock_period

	// Scenario: oversampled mode, serial conflict refused
	task automatic oversampled();
		int n;
		pattern <= 16'hFFFF;
		setup(FTX_MOD_2L, 9'h003, 4'h2, 8'h03, 3'h5);
		repeat (4) @(negedge ref_clk);
		chk("tx_active conflict", 32'h0, 32'(tx_active));
		wb_xfer(1'b0, FTX_ADDR_STAT, 32'h0, rd);
		chk("status conflict", 32'h1, 32'(rd[1]));
		wb_xfer(1'b1, FTX_ADDR_CFG2, {4'h0, 9'h003, 12'h0, FTX_MOD_2L_OVER, 4'h0}, rd);
		wait_strobe();
		wait_strobe();
		n = 2;
		while (symbol_strobe !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		chk("oversample period", 32'd6, 32'(n));
		chk("clock pin oe oversampled", 32'h0, 32'(transceive_clock_pin_oe));
		chk("oversample level", 32'h1, 32'(symbol_level));
		wb_xfer(1'b1, FTX_ADDR_CFG2, {4'h0, 9'h003, 12'h0, FTX_MOD_2L, 4'h0}, rd);
		repeat (3) @(negedge ref_clk);
		chk("tx_active dropped", 32'h0, 32'(tx_active));
	endtask : oversampled

	// Scenario: every modulation code against filter outputs
	task automatic filter_codes();
		logic [2:0] m;
		for (int c = 0; c < 16; c++) begin
			m = 3'(c);
			wb_xfer(1'b1, FTX_ADDR_CFG2, {1'b0, c[3], 2'h0, 9'h001, 12'h0, m, 4'h0}, rd);
			repeat (3) @(negedge ref_clk);
			chk("filter_select", (m == 3'h1) ? 32'h1 : (m > 3'h4) ? 32'h2 : 32'h0, 32'(filter_select));
			chk("rc_alpha_high", 32'(c[3] && m > 3'h4), 32'(rc_alpha_high));
		end
	endtask : filter_codes

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		wb_xfer(1'b0, FTX_ADDR_CFG2, 32'h0, rd);
		chk("cfg2 reset", 32'h0008_0000, rd);
		wb_xfer(1'b0, FTX_ADDR_CFG3, 32'h0, rd);
		chk("cfg3 reset", 32'h0000_0440, rd);
		wb_xfer(1'b0, 4'h1, 32'h0, rd);
		chk("unmapped read", 32'h0, rd);
		clock_period();
		run_symbols(FTX_MOD_2L, 16'hB3A5, 8, 1, 9'h005, 1'b0);
		run_symbols(FTX_MOD_3L, 16'hB240, 10, 0, 9'h1FF, 1'b0);
		run_symbols(FTX_MOD_4L, 16'h1E00, 4, 1, 9'h007, 1'b1);
		run_symbols(FTX_MOD_2L, 16'h5A00, 4, 1, 9'h0C8, 1'b1);
		filter_codes();
		oversampled();
		test_done();
	end
endmodule : tb_top
